/* hw/pll_power_status_regs.svh */
// register offsets, field positions, reset values and timing counts
// assumes one include per compile unit; guard protects repeats
`ifndef PLL_POWER_STATUS_REGS_SVH
`define PLL_POWER_STATUS_REGS_SVH
`define ADDR_PWR_CTRL 8'h05
`define ADDR_CALWORD 8'h06
`define ADDR_LOCK_STATUS 8'h07
`define ADDR_MISC 8'h08
`define ADDR_LAST 8'h3f
`define PWR_RESET 16'h0030
`define PWR_WR_MASK 16'h07e1
`define B_REF 0
`define B_PSFB 1
`define B_PFD 2
`define B_FODCLK 3
`define B_PSFBA 4
`define B_PSFBB 5
`define B_LOCKDET 6
`define B_CP 7
`define B_VCOBUF 8
`define B_VCO 9
`define B_VCOBUF2 10
`define S_LOCK 0
`define S_UNLOCK 1
`define S_CFG 2
`define S_CAL 3
`define S_BUSY 4
`define S_CRC 5
`define S_WRERR 6
`define S_RDERR 7
`define S_NVWR 8
`define S_NVRD 9
`define S_PORV 10
`define S_LOCKA 11
`define POR_TIME_NS 200
`define POR_CYC ((`POR_TIME_NS + 19) / 20)
`endif

/* hw/pll_power_status_pkg.sv */
// types shared by the power and status register bank
// assumes the _regs header supplies the numbers
package pll_power_status_pkg;
    typedef enum logic [2:0] {
        ST_POR = 3'b001,
        ST_WAIT_CAL = 3'b010,
        ST_RUN = 3'b100
    } pll_seq_t;
    typedef logic [15:0] word_t;
endpackage

/* hw/status_sticky.sv */
// one sticky status flag: set wins over clear
// assumes synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module status_sticky (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic set_in,
    input wire logic clr_in,
    output var logic flag_r
);
    typedef struct packed {
        logic flag;
    } sticky_state_t;
    sticky_state_t st_r;
    sticky_state_t st_nxt;
    always_comb
    begin
        st_nxt = st_r;
        if (set_in)
        begin
            st_nxt.flag = 1'b1;
        end
        else if (clr_in)
        begin
            st_nxt.flag = 1'b0;
        end
    end
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign flag_r = st_r.flag;
endmodule
`default_nettype wire

/* hw/pll_power_status_regs.sv */
// pll power-down controls and calibration/lock/nvm status registers
// assumes a serial front end gives one-cycle rd/wr strobes with 8-bit address
`timescale 1ns/1ps
`default_nettype none
`include "pll_power_status_regs.svh"
module pll_power_status_regs (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reset_sync_pin_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic [15:0] cal_word_in,
    input wire logic [15:0] misc_word_in,
    input wire logic cal_start,
    input wire logic cal_finish,
    input wire logic cfg_finish,
    input wire logic crc_mismatch,
    input wire logic nvm_active,
    input wire logic nvm_rd_phase,
    input wire logic nvm_wr_phase,
    input wire logic nvm_op_req,
    input wire logic lock_in,
    input wire logic lock_analog_in,
    input wire logic vcobuf_por_in,
    output logic [15:0] pll_power_r,
    output logic status_busy_r
);
    import pll_power_status_pkg::*;

    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        pll_seq_t seq;
        logic [7:0] por_cnt;
        logic [15:0] pwr;
        logic [15:0] rdata;
        logic cal;
        logic cfg;
        logic crc;
        logic busy;
        logic rderr;
        logic wrerr;
        logic lock;
        logic locka;
        logic porv;
    } bank_state_t;

    bank_state_t st_r;
    bank_state_t st_nxt;
    logic hard_rst;
    logic nvrd_flag;
    logic nvwr_flag;
    logic unlock_flag;
    logic rd_status;
    logic recal;

    function automatic logic above_last(input logic [7:0] a);
        above_last = a > `ADDR_LAST;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // hard reset from the pin acts like power-on reset for the bank
    assign hard_rst = sys_rst | ~reset_sync_pin_n;
    assign rd_status = reg_rd & (reg_addr == `ADDR_LOCK_STATUS);
    assign recal = cal_start;

    status_sticky u_nvrd (
        .clk(clk),
        .sys_rst(hard_rst),
        .set_in(nvm_op_req & nvm_rd_phase),
        .clr_in(rd_status),
        .flag_r(nvrd_flag)
    );
    status_sticky u_nvwr (
        .clk(clk),
        .sys_rst(hard_rst),
        .set_in(nvm_op_req & nvm_wr_phase),
        .clr_in(rd_status),
        .flag_r(nvwr_flag)
    );
    // recalibration clears, but a fresh loss in that cycle still wins
    status_sticky u_unlock (
        .clk(clk),
        .sys_rst(hard_rst),
        .set_in(st_r.cal & st_r.lock & ~lock_in),
        .clr_in(recal),
        .flag_r(unlock_flag)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.busy = nvm_active;
        st_nxt.lock = lock_in;
        st_nxt.locka = lock_analog_in;
        st_nxt.porv = vcobuf_por_in;
        if (cal_finish)
        begin
            st_nxt.cal = 1'b1;
        end
        else if (recal)
        begin
            st_nxt.cal = 1'b0;
        end
        if (cfg_finish)
        begin
            st_nxt.cfg = 1'b1;
        end
        if (crc_mismatch)
        begin
            st_nxt.crc = 1'b1;
        end
        if (reg_rd && above_last(reg_addr))
        begin
            st_nxt.rderr = 1'b1;
        end
        if (reg_wr && above_last(reg_addr))
        begin
            st_nxt.wrerr = 1'b1;
        end
        // power-up sequencer drives the state-machine bits
        case (st_r.seq)
            ST_POR:
            begin
                st_nxt.pwr[`B_PSFBA] = 1'b0;
                st_nxt.pwr[`B_FODCLK] = 1'b0;
                st_nxt.pwr[`B_PSFB] = 1'b0;
                st_nxt.pwr[`B_PFD] = 1'b1;
                st_nxt.por_cnt = st_r.por_cnt + 8'h01;
                if (st_r.por_cnt == 8'(`POR_CYC - 1))
                begin
                    st_nxt.seq = ST_WAIT_CAL;
                    st_nxt.pwr[`B_PSFBA] = 1'b1;
                    st_nxt.pwr[`B_FODCLK] = 1'b1;
                    st_nxt.pwr[`B_PSFB] = 1'b1;
                end
            end
            ST_WAIT_CAL:
            begin
                st_nxt.pwr[`B_PFD] = 1'b1;
                if (st_r.cal)
                begin
                    st_nxt.pwr[`B_PFD] = 1'b0;
                    st_nxt.seq = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (recal)
                begin
                    st_nxt.pwr[`B_PFD] = 1'b1;
                    st_nxt.seq = ST_WAIT_CAL;
                end
            end
            default:
            begin
                st_nxt.seq = ST_POR;
            end
        endcase
        // software owns the plain power-down bits; sequencer bits are not writable
        if (reg_wr && reg_addr == `ADDR_PWR_CTRL)
        begin
            st_nxt.pwr = (st_r.pwr & ~`PWR_WR_MASK) | (reg_wdata & `PWR_WR_MASK);
        end
        // input path kill bit stays writable; keeping it clear is up to the host
        // read data registered one cycle after the strobe
        if (reg_rd)
        begin
            case (reg_addr)
                `ADDR_PWR_CTRL: st_nxt.rdata = st_r.pwr;
                `ADDR_CALWORD: st_nxt.rdata = cal_word_in;
                `ADDR_LOCK_STATUS:
                begin
                    st_nxt.rdata = 16'h0000;
                    st_nxt.rdata[`S_LOCKA] = st_r.locka;
                    st_nxt.rdata[`S_PORV] = st_r.porv;
                    st_nxt.rdata[`S_NVRD] = nvrd_flag;
                    st_nxt.rdata[`S_NVWR] = nvwr_flag;
                    st_nxt.rdata[`S_RDERR] = st_r.rderr;
                    st_nxt.rdata[`S_WRERR] = st_r.wrerr;
                    st_nxt.rdata[`S_CRC] = st_r.crc;
                    st_nxt.rdata[`S_BUSY] = st_r.busy;
                    st_nxt.rdata[`S_CAL] = st_r.cal;
                    st_nxt.rdata[`S_CFG] = st_r.cfg;
                    st_nxt.rdata[`S_UNLOCK] = unlock_flag;
                    st_nxt.rdata[`S_LOCK] = st_r.lock;
                end
                `ADDR_MISC: st_nxt.rdata = misc_word_in;
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (hard_rst)
        begin
            st_r <= '0;
            st_r.seq <= ST_POR;
            st_r.pwr <= `PWR_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign pll_power_r = st_r.pwr;
    assign status_busy_r = st_r.busy;

    ////////////////////////////////////////////////////////////////////
    // steps of the power-up and recalibration flow, plus lock loss, power register writes and reads beyond the last register
    sequence s_por_last;
        st_r.seq == ST_POR && st_r.por_cnt == 8'(`POR_CYC - 1);
    endsequence
    sequence s_cal_seen;
        st_r.cal && st_r.seq == ST_WAIT_CAL;
    endsequence
    sequence s_recal_run;
        st_r.seq == ST_RUN && recal;
    endsequence
    sequence s_lock_lost;
        st_r.cal && st_r.lock && !lock_in;
    endsequence
    sequence s_pwr_write;
        reg_wr && reg_addr == `ADDR_PWR_CTRL;
    endsequence
    sequence s_run_write;
        reg_wr && reg_addr == `ADDR_PWR_CTRL && st_r.seq == ST_RUN && !recal;
    endsequence
    sequence s_rd_beyond;
        reg_rd && above_last(reg_addr);
    endsequence

    a_seq_onehot: assert property (@(posedge clk) disable iff (hard_rst)
        $onehot(st_r.seq))
        else $error("sequencer state not one-hot");
    // por_cnt is still 0 on the first edge after reset, when reset values still show
    a_por_low: assert property (@(posedge clk) disable iff (hard_rst)
        st_r.seq == ST_POR && st_r.por_cnt != 8'h00 |-> !pll_power_r[`B_PSFBA] && !pll_power_r[`B_PSFB])
        else $error("prescaler not low in por");
    a_por_fod_low: assert property (@(posedge clk) disable iff (hard_rst)
        st_r.seq == ST_POR && st_r.por_cnt != 8'h00 |-> !pll_power_r[`B_FODCLK] && pll_power_r[`B_PFD])
        else $error("fod clock path not low in por");
    a_por_exit: assert property (@(posedge clk) disable iff (hard_rst)
        s_por_last |=> st_r.seq == ST_WAIT_CAL && pll_power_r[`B_FODCLK])
        else $error("power-on sequence did not end");
    a_post_por: assert property (@(posedge clk) disable iff (hard_rst)
        st_r.seq != ST_POR |-> pll_power_r[`B_PSFB] && pll_power_r[`B_FODCLK])
        else $error("sequencer bits not high");
    a_fixed_bits: assert property (@(posedge clk) disable iff (hard_rst)
        s_run_write |=> pll_power_r[`B_PSFBA:`B_PSFB] == $past(pll_power_r[`B_PSFBA:`B_PSFB]))
        else $error("sequencer bits moved by a write");

    a_pfd_hold: assert property (@(posedge clk) disable iff (hard_rst)
        (st_r.seq == ST_WAIT_CAL && !st_r.cal) |-> pll_power_r[`B_PFD])
        else $error("pfd enabled early");
    a_pfd_release: assert property (@(posedge clk) disable iff (hard_rst)
        s_cal_seen |=> !pll_power_r[`B_PFD])
        else $error("pfd not released");
    a_pfd_recal: assert property (@(posedge clk) disable iff (hard_rst)
        s_recal_run |=> pll_power_r[`B_PFD] && st_r.seq == ST_WAIT_CAL)
        else $error("pfd not disabled on recalibration");

    a_pwr_write: assert property (@(posedge clk) disable iff (hard_rst)
        s_pwr_write |=> pll_power_r[`B_PSFBB] == $past(reg_wdata[`B_PSFBB]))
        else $error("power write lost");
    a_plain_write: assert property (@(posedge clk) disable iff (hard_rst)
        s_pwr_write |=> pll_power_r[`B_VCOBUF2:`B_PSFBB] == $past(reg_wdata[`B_VCOBUF2:`B_PSFBB]))
        else $error("power-down bits not written");

    a_porv_track: assert property (@(posedge clk) disable iff (hard_rst)
        1'b1 |=> st_r.porv == $past(vcobuf_por_in))
        else $error("regulator por bit stale");
    a_nvrd_set: assert property (@(posedge clk) disable iff (hard_rst)
        nvm_op_req && nvm_rd_phase |=> nvrd_flag)
        else $error("read phase error not set");
    a_nvrd_clear: assert property (@(posedge clk) disable iff (hard_rst)
        rd_status && !(nvm_op_req && nvm_rd_phase) |=> !nvrd_flag)
        else $error("read error not cleared");
    a_nvwr_set: assert property (@(posedge clk) disable iff (hard_rst)
        nvm_op_req && nvm_wr_phase |=> nvwr_flag)
        else $error("write error not set");
    a_nvwr_clear: assert property (@(posedge clk) disable iff (hard_rst)
        rd_status && !(nvm_op_req && nvm_wr_phase) |=> !nvwr_flag)
        else $error("write phase error not cleared");
    a_rderr_set: assert property (@(posedge clk) disable iff (hard_rst)
        s_rd_beyond |=> st_r.rderr)
        else $error("rd error missed");
    a_rderr_data: assert property (@(posedge clk) disable iff (hard_rst)
        s_rd_beyond |=> reg_rdata == 16'h0000)
        else $error("read beyond last register not zero");
    a_rderr_keep: assert property (@(posedge clk) disable iff (hard_rst)
        st_r.rderr |=> st_r.rderr)
        else $error("rd error lost");
    a_wrerr_set: assert property (@(posedge clk) disable iff (hard_rst)
        reg_wr && above_last(reg_addr) |=> st_r.wrerr)
        else $error("wr error missed");
    a_wrerr_keep: assert property (@(posedge clk) disable iff (hard_rst)
        st_r.wrerr |=> st_r.wrerr)
        else $error("wr error lost");
    a_crc_set: assert property (@(posedge clk) disable iff (hard_rst)
        crc_mismatch |=> st_r.crc)
        else $error("crc error missed");
    a_busy_follow: assert property (@(posedge clk) disable iff (hard_rst)
        nvm_active |=> status_busy_r)
        else $error("busy missed");
    a_busy_drop: assert property (@(posedge clk) disable iff (hard_rst)
        !nvm_active |=> !status_busy_r)
        else $error("busy not cleared");
    a_cal_set: assert property (@(posedge clk) disable iff (hard_rst)
        cal_finish |=> st_r.cal)
        else $error("calibration done missed");
    a_cfg_set: assert property (@(posedge clk) disable iff (hard_rst)
        cfg_finish |=> st_r.cfg)
        else $error("configuration done missed");
    a_unlock_set: assert property (@(posedge clk) disable iff (hard_rst)
        s_lock_lost |=> unlock_flag)
        else $error("loss of lock missed");
    a_unlock_clear: assert property (@(posedge clk) disable iff (hard_rst)
        recal && !(st_r.cal && st_r.lock && !lock_in) |=> !unlock_flag)
        else $error("loss of lock not cleared");
    a_lock_track: assert property (@(posedge clk) disable iff (hard_rst)
        1'b1 |=> st_r.lock == $past(lock_in))
        else $error("lock bit stale");
endmodule
`default_nettype wire

/* dv/reg_host.sv */
// host model: single-word register reads and writes on the strobe port
// assumes the bench calls its tasks; signals move at the falling edge
`timescale 1ns/1ps
`default_nettype none
module reg_host (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata
);
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // kill switch bit forced low: setting it would cut the reference path
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d & 16'hfffe;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        @(negedge clk);
    endtask
    // data held by the design until the next read, so one spare edge is safe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* dv/pll_power_status_regs_tb.sv */
// self-checking bench for the pll power and status register bank
// assumes reg_host drives the register strobes; all else driven here
`timescale 1ns/1ps
`default_nettype none
module pll_power_status_regs_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic pin_n = 1'b1;
    logic wr, rd;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, pwr, v;
    logic busy;
    logic cal_start = 1'b0, cal_fin = 1'b0, cfg_fin = 1'b0, crc = 1'b0, nv_act = 1'b0;
    logic nv_rd = 1'b0, nv_wr = 1'b0, nv_req = 1'b0, lock = 1'b0, lock_a = 1'b0, por = 1'b0;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    initial
    begin
        forever #10 clk = ~clk;
    end
    reg_host host (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata));
    pll_power_status_regs dut (.clk(clk), .sys_rst(sys_rst), .reset_sync_pin_n(pin_n),
        .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .cal_word_in(16'h1234), .misc_word_in(16'hbeef), .cal_start(cal_start),
        .cal_finish(cal_fin), .cfg_finish(cfg_fin), .crc_mismatch(crc),
        .nvm_active(nv_act), .nvm_rd_phase(nv_rd), .nvm_wr_phase(nv_wr),
        .nvm_op_req(nv_req), .lock_in(lock), .lock_analog_in(lock_a),
        .vcobuf_por_in(por), .pll_power_r(pwr), .status_busy_r(busy));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic st(input logic [15:0] e);
        host.rd(8'h07, v);
        chk("status", e, v);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // generous ceiling: the whole run needs well under 1000 cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            num_errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        repeat (4) @(negedge clk);
        chk("pwr in reset", 16'h0030, pwr);
        chk("busy in reset", 16'h0000, {15'h0, busy});
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        chk("pwr in por", 16'h0024, pwr);
        repeat (15) @(negedge clk);
        chk("pwr after por", 16'h003e, pwr);
        $display("t_reset done");
    endtask
    task automatic t_cal;
        lock = 1'b1;
        lock_a = 1'b1;
        por = 1'b1;
        cfg_fin = 1'b1;
        @(negedge clk);
        cfg_fin = 1'b0;
        cal_fin = 1'b1;
        @(negedge clk);
        cal_fin = 1'b0;
        repeat (2) @(negedge clk);
        chk("pwr after cal", 16'h003a, pwr);
        st(16'h0c0d);
        host.rd(8'h06, v);
        chk("cal word", 16'h1234, v);
        host.rd(8'h08, v);
        chk("misc word", 16'hbeef, v);
        $display("t_cal done");
    endtask
    task automatic t_pwr;
        host.wr(8'h05, 16'hf7c0);
        chk("pwr all off", 16'h07da, pwr);
        host.rd(8'h05, v);
        chk("pwr readback", 16'h07da, v);
        host.wr(8'h05, 16'h0000);
        chk("pwr all on", 16'h001a, pwr);
        $display("t_pwr done");
    endtask
    task automatic t_nvm;
        nv_rd = 1'b1;
        nv_req = 1'b1;
        @(negedge clk);
        nv_req = 1'b0;
        nv_rd = 1'b0;
        st(16'h0e0d);
        st(16'h0c0d);
        nv_wr = 1'b1;
        nv_req = 1'b1;
        @(negedge clk);
        nv_req = 1'b0;
        nv_wr = 1'b0;
        st(16'h0d0d);
        nv_act = 1'b1;
        repeat (2) @(negedge clk);
        chk("busy", 16'h0001, {15'h0, busy});
        st(16'h0c1d);
        nv_act = 1'b0;
        crc = 1'b1;
        @(negedge clk);
        crc = 1'b0;
        st(16'h0c2d);
        st(16'h0c2d);
        $display("t_nvm done");
    endtask
    task automatic t_unlock;
        lock = 1'b0;
        st(16'h0c2e);
        lock = 1'b1;
        st(16'h0c2f);
        cal_start = 1'b1;
        @(negedge clk);
        cal_start = 1'b0;
        chk("pwr recal", 16'h001e, pwr);
        st(16'h0c25);
        cal_fin = 1'b1;
        @(negedge clk);
        cal_fin = 1'b0;
        st(16'h0c2d);
        chk("pwr relock", 16'h001a, pwr);
        $display("t_unlock done");
    endtask
    task automatic t_addr;
        host.wr(8'h07, 16'hffff);
        st(16'h0c2d);
        host.rd(8'h40, v);
        chk("rd beyond", 16'h0000, v);
        st(16'h0cad);
        host.wr(8'h40, 16'h5555);
        st(16'h0ced);
        lock = 1'b0;
        @(negedge clk);
        lock = 1'b1;
        st(16'h0cef);
        pin_n = 1'b0;
        por = 1'b0;
        repeat (2) @(negedge clk);
        chk("pwr hard reset", 16'h0030, pwr);
        pin_n = 1'b1;
        st(16'h0801);
        $display("t_addr done");
    endtask
    initial
    begin
        t_reset();
        t_cal();
        t_pwr();
        t_nvm();
        t_unlock();
        t_addr();
        wrap_up();
    end
endmodule
`default_nettype wire
